//--- design/csb_exec.sv
/*
 * execute slice for clear-acc, dec/inc-skip, jump and or-literal
 * assumes instruction and file read data arrive on core_clk, same cycle
 */
// Overview of operation
// RQ1 - clear acc loads zero, sets zero flag
// RQ2 - dec-skip subtracts one from file register
// RQ3 - inc-skip adds one to file register
// RQ4 - dest bit zero to acc, one to file
// RQ5 - zero skip result turns next into nop
// RQ6 - jump loads 11-bit immediate into pc low
// RQ7 - pc bits 12:11 from page latch 4:3
// RQ8 - jump takes two instruction cycles
// RQ9 - or literal into acc, result in acc
// RQ10 - or sets zero flag; skips keep flags
`default_nettype none

module csb_exec (
   input  wire logic                        core_clk,
   input  wire logic                        rstn,
   input  wire csb_pkg::csb_instr_t         instr,
   input  wire logic [csb_pkg::ACC_W-1:0]   file_rdata,
   input  wire logic [csb_pkg::PAGE_W-1:0]  pc_page_latch,
   output var  logic [csb_pkg::ACC_W-1:0]   acc_ff,
   output var  logic                        zero_ff,
   output var  csb_pkg::csb_fwr_t           fwr_ff,
   output var  logic                        pc_load_ff,
   output var  logic [csb_pkg::PC_W-1:0]    pc_ff,
   output var  logic                        nop_cycle_ff
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // true when an 8-bit value is all zero
   function automatic logic is_zero(input logic [csb_pkg::ACC_W-1:0] v);
      is_zero = (v == csb_pkg::ACC_ZERO);
   endfunction : is_zero

   // step a file value by one, down or up
   function automatic logic [csb_pkg::ACC_W-1:0] step(
      input logic [csb_pkg::ACC_W-1:0] v,
      input logic                      down);
      step = down ? csb_pkg::ACC_W'(v - csb_pkg::ACC_ONE)
                  : csb_pkg::ACC_W'(v + csb_pkg::ACC_ONE);
   endfunction : step

   ////////////////////////////////////////////////////////////////////
   // decode of the issued instruction

   csb_pkg::csb_state_t          state_ff;     // run or discard
   csb_pkg::csb_state_t          nxt_state;    // next state
   logic                         issue;        // instruction really runs
   logic                         is_skip;      // either skip op
   logic [csb_pkg::ACC_W-1:0]    skip_res;     // stepped file value
   logic                         skip_taken;   // skip result is zero
   logic [csb_pkg::ACC_W-1:0]    or_res;       // acc or literal
   logic [csb_pkg::ACC_W-1:0]    lit;          // 8-bit literal

   // a discarded instruction never issues
   assign issue = instr.valid && (state_ff == csb_pkg::CSB_ST_RUN);
   assign is_skip = (instr.op == csb_pkg::CSB_OP_DEC_SKIP) ||
                    (instr.op == csb_pkg::CSB_OP_INC_SKIP);
   // dec and inc share one stepper
   assign skip_res = step(file_rdata,
                          instr.op == csb_pkg::CSB_OP_DEC_SKIP); // RQ2 RQ3
   assign skip_taken = is_zero(skip_res);                        // RQ5
   assign lit = instr.imm[csb_pkg::ACC_W-1:0];
   assign or_res = acc_ff | lit;                                  // RQ9

   ////////////////////////////////////////////////////////////////////
   // next state: jump and taken skip discard the following slot
   always_comb begin
      nxt_state = csb_pkg::CSB_ST_RUN;
      if (issue) begin
         case (instr.op)
            csb_pkg::CSB_OP_JUMP: begin
               nxt_state = csb_pkg::CSB_ST_DISCARD;               // RQ8
            end
            csb_pkg::CSB_OP_DEC_SKIP,
            csb_pkg::CSB_OP_INC_SKIP: begin
               if (skip_taken) begin
                  nxt_state = csb_pkg::CSB_ST_DISCARD;            // RQ5
               end
            end
            default: begin
               nxt_state = csb_pkg::CSB_ST_RUN;
            end
         endcase
      end
   end

   // state register; nop flag mirrors the discard slot
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff     <= csb_pkg::CSB_ST_RUN;
         nop_cycle_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         nop_cycle_ff <= (nxt_state == csb_pkg::CSB_ST_DISCARD);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // working register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_ff <= csb_pkg::ACC_RST;
      end else if (issue) begin
         case (instr.op)
            csb_pkg::CSB_OP_CLR_ACC: begin
               acc_ff <= csb_pkg::ACC_ZERO;                       // RQ1
            end
            csb_pkg::CSB_OP_DEC_SKIP,
            csb_pkg::CSB_OP_INC_SKIP: begin
               if (instr.dest == csb_pkg::DEST_ACC) begin
                  acc_ff <= skip_res;                             // RQ4
               end
            end
            csb_pkg::CSB_OP_OR_LIT: begin
               acc_ff <= or_res;                                  // RQ9
            end
            default: begin
               acc_ff <= acc_ff;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // zero flag; skips and jump leave it alone
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         zero_ff <= 1'b0;
      end else if (issue) begin
         case (instr.op)
            csb_pkg::CSB_OP_CLR_ACC: begin
               zero_ff <= 1'b1;                                   // RQ1
            end
            csb_pkg::CSB_OP_OR_LIT: begin
               zero_ff <= is_zero(or_res);                        // RQ10
            end
            default: begin
               zero_ff <= zero_ff;                                // RQ10
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // file write-back strobe, one cycle per skip with dest one
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fwr_ff.en   <= 1'b0;
         fwr_ff.addr <= csb_pkg::ADDR_RST;
         fwr_ff.data <= csb_pkg::ACC_RST;
      end else begin
         fwr_ff.en <= issue && is_skip &&
                      (instr.dest == csb_pkg::DEST_FILE);          // RQ4
         if (issue && is_skip) begin
            fwr_ff.addr <= instr.faddr;
            fwr_ff.data <= skip_res;                              // RQ2 RQ3
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // program counter load for the jump
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pc_load_ff <= 1'b0;
         pc_ff      <= csb_pkg::PC_RST;
      end else begin
         pc_load_ff <= issue && (instr.op == csb_pkg::CSB_OP_JUMP);
         if (issue && (instr.op == csb_pkg::CSB_OP_JUMP)) begin
            // page bits on top, immediate below
            pc_ff <= {pc_page_latch[csb_pkg::PAGE_HI:csb_pkg::PAGE_LO],
                      instr.imm};                                 // RQ6 RQ7
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions

   // an issued instruction of a given kind
   sequence s_jump;
      issue && instr.op == csb_pkg::CSB_OP_JUMP;
   endsequence

   sequence s_skip_zero;
      issue && is_skip && skip_taken;
   endsequence

   property p_clr_acc;
      @(posedge core_clk) disable iff (!rstn)
      issue && instr.op == csb_pkg::CSB_OP_CLR_ACC |=>
         acc_ff == csb_pkg::ACC_ZERO && zero_ff;
   endproperty
   a_clr_acc: assert property (p_clr_acc)  // RQ1
      else $error("clear acc did not zero acc and set flag");

   property p_dec_acc;
      @(posedge core_clk) disable iff (!rstn)
      issue && instr.op == csb_pkg::CSB_OP_DEC_SKIP &&
      instr.dest == csb_pkg::DEST_ACC |=>
         acc_ff == csb_pkg::ACC_W'($past(file_rdata) - csb_pkg::ACC_ONE) &&
         !fwr_ff.en;
   endproperty
   a_dec_acc: assert property (p_dec_acc)  // RQ2
      else $error("dec skip to acc gave wrong result");

   property p_inc_file;
      @(posedge core_clk) disable iff (!rstn)
      issue && instr.op == csb_pkg::CSB_OP_INC_SKIP &&
      instr.dest == csb_pkg::DEST_FILE |=>
         fwr_ff.en && fwr_ff.addr == $past(instr.faddr) &&
         fwr_ff.data ==
            csb_pkg::ACC_W'($past(file_rdata) + csb_pkg::ACC_ONE) &&
         acc_ff == $past(acc_ff);
   endproperty
   a_inc_file: assert property (p_inc_file)  // RQ3
      else $error("inc skip to file gave wrong write");

   property p_dest_sel;
      @(posedge core_clk) disable iff (!rstn)
      issue && is_skip |=> fwr_ff.en == $past(instr.dest);
   endproperty
   a_dest_sel: assert property (p_dest_sel)  // RQ4
      else $error("skip destination select not honoured");

   property p_skip;
      @(posedge core_clk) disable iff (!rstn)
      issue && is_skip |=> nop_cycle_ff == $past(skip_taken);
   endproperty
   a_skip: assert property (p_skip)  // RQ5
      else $error("skip did not match result zero");

   property p_skip_nop;
      @(posedge core_clk) disable iff (!rstn)
      s_skip_zero |=> nop_cycle_ff ##1
         (!nop_cycle_ff && $stable(acc_ff) && $stable(zero_ff) &&
          !fwr_ff.en && !pc_load_ff);
   endproperty
   a_skip_nop: assert property (p_skip_nop)  // RQ5
      else $error("taken skip did not insert one nop");

   property p_jump_pc;
      @(posedge core_clk) disable iff (!rstn)
      s_jump |=> pc_load_ff &&
         pc_ff == {$past(pc_page_latch[csb_pkg::PAGE_HI:csb_pkg::PAGE_LO]),
                   $past(instr.imm)};
   endproperty
   a_jump_pc: assert property (p_jump_pc)  // RQ6 RQ7
      else $error("jump loaded wrong program counter");

   property p_jump_two;
      @(posedge core_clk) disable iff (!rstn)
      s_jump |=> nop_cycle_ff ##1 !nop_cycle_ff && !pc_load_ff;
   endproperty
   a_jump_two: assert property (p_jump_two)  // RQ8
      else $error("jump did not take exactly two cycles");

   property p_or_lit;
      @(posedge core_clk) disable iff (!rstn)
      issue && instr.op == csb_pkg::CSB_OP_OR_LIT |=>
         acc_ff == ($past(acc_ff) | $past(lit)) &&
         zero_ff == (acc_ff == csb_pkg::ACC_ZERO);
   endproperty
   a_or_lit: assert property (p_or_lit)  // RQ9 RQ10
      else $error("or literal result or zero flag wrong");

   property p_skip_flags;
      @(posedge core_clk) disable iff (!rstn)
      issue && (is_skip || instr.op == csb_pkg::CSB_OP_JUMP) |=>
         $stable(zero_ff);
   endproperty
   a_skip_flags: assert property (p_skip_flags)  // RQ10
      else $error("skip or jump changed the zero flag");

endmodule : csb_exec

`default_nettype wire

//--- design/csb_pkg.sv
/*
 * shared types and constants for the skip/branch/or execute slice
 * assumes a single core clock; decode happens upstream of this slice
 */
`default_nettype none

package csb_pkg;

   ////////////////////////////////////////////////////////////////////
   // widths
   localparam int ACC_W  = 8;     // working register width
   localparam int ADDR_W = 7;     // file register address width
   localparam int IMM_W  = 11;    // jump immediate width
   localparam int PC_W   = 13;    // program counter width
   localparam int PAGE_W = 8;     // page latch register width

   // page latch bits that feed pc bits 12 and 11
   localparam int PAGE_HI = 4;
   localparam int PAGE_LO = 3;

   // reset values
   localparam logic [ACC_W-1:0]  ACC_RST  = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
   localparam logic [ACC_W-1:0]  ACC_ZERO = 8'h00;   // cleared value
   localparam logic [ACC_W-1:0]  ACC_ONE  = 8'h01;   // step size

   ////////////////////////////////////////////////////////////////////
   // operation selected by the upstream decoder
   typedef enum logic [2:0] {
      CSB_OP_NONE     = 3'b000,   // some other instruction
      CSB_OP_CLR_ACC  = 3'b001,   // clear_working_reg
      CSB_OP_DEC_SKIP = 3'b010,   // dec_skip_if_zero
      CSB_OP_INC_SKIP = 3'b011,   // inc_skip_if_zero
      CSB_OP_JUMP     = 3'b100,   // jump_immediate
      CSB_OP_OR_LIT   = 3'b101    // or_literal_into_acc
   } csb_op_t;

   // destination select bit values
   localparam logic DEST_ACC  = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // slice state
   typedef enum logic [0:0] {
      CSB_ST_RUN     = 1'b0,      // next instruction executes
      CSB_ST_DISCARD = 1'b1       // next instruction becomes a nop
   } csb_state_t;

   ////////////////////////////////////////////////////////////////////
   // one issued instruction
   typedef struct packed {
      logic              valid;   // instruction present this cycle
      csb_op_t           op;      // decoded operation
      logic [ADDR_W-1:0] faddr;   // file register address
      logic              dest;    // destination select
      logic [IMM_W-1:0]  imm;     // immediate; literal in low 8 bits
   } csb_instr_t;

   // write-back toward the file register array
   typedef struct packed {
      logic              en;      // one-cycle write strobe
      logic [ADDR_W-1:0] addr;    // target address
      logic [ACC_W-1:0]  data;    // write data
   } csb_fwr_t;

endpackage : csb_pkg

`default_nettype wire

//--- test/csb_file_model.sv
/*
 * file register array that stands beside the execute slice
 * assumes write strobes are sampled on core_clk rising edges
 */
`default_nettype none

module csb_file_model (
   input  wire logic                       core_clk,
   input  wire logic [csb_pkg::ADDR_W-1:0] faddr,
   input  wire csb_pkg::csb_fwr_t          fwr,
   output logic [csb_pkg::ACC_W-1:0]       file_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [csb_pkg::ACC_W-1:0] mem [0:127];   // register contents

   // start from a known clear array
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'h00;
      end
   end

   // read port answers in the same cycle as the address
   assign file_rdata = mem[faddr];

   // take whatever the slice writes back
   always @(posedge core_clk) begin
      if (fwr.en) begin
         mem[fwr.addr] <= fwr.data;
      end
   end
endmodule : csb_file_model

`default_nettype wire

//--- test/tb_core_skip_branch_or_ops.sv
/*
 * self-checking bench for the skip/branch/or execute slice
 * assumes csb_pkg, csb_exec and csb_file_model are compiled first
 */
`default_nettype none

module tb_core_skip_branch_or_ops;
   timeunit 1ns;
   timeprecision 1ns;

   logic                core_clk;       // 20 MHz core clock
   logic                rstn;           // active low reset
   csb_pkg::csb_instr_t instr;          // issued instruction
   logic [7:0]          file_rdata;     // file read data
   logic [7:0]          page;           // page latch
   logic [7:0]          acc_ff;         // working register
   logic                zero_ff;        // zero flag
   csb_pkg::csb_fwr_t   fwr_ff;         // write-back
   logic                pc_load_ff;     // pc load pulse
   logic [12:0]         pc_ff;          // jump target
   logic                nop_cycle_ff;   // discarded slot
   int                  fails;          // mismatches
   int                  compares;       // comparisons
   logic [7:0]          exp_acc;        // expected acc
   logic                exp_zero;       // expected flag

   csb_exec csb_exec_inst (
      .core_clk(core_clk), .rstn(rstn), .instr(instr),
      .file_rdata(file_rdata), .pc_page_latch(page), .acc_ff(acc_ff),
      .zero_ff(zero_ff), .fwr_ff(fwr_ff), .pc_load_ff(pc_load_ff),
      .pc_ff(pc_ff), .nop_cycle_ff(nop_cycle_ff));

   csb_file_model csb_file_model_inst (
      .core_clk(core_clk), .faddr(instr.faddr), .fwr(fwr_ff),
      .file_rdata(file_rdata));

   ////////////////////////////////////////////////////////////////////
   // clock with a 50 ns period
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // one compare for every value and flag
   task automatic chk(string n, logic [12:0] e, logic [12:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // builds a valid instruction
   function automatic csb_pkg::csb_instr_t mk(csb_pkg::csb_op_t op,
         logic [6:0] fa, logic d, logic [10:0] im);
      mk = '{1'b1, op, fa, d, im};
   endfunction : mk

   // next edge with a new instruction, then settle
   task automatic slot(csb_pkg::csb_instr_t a);
      @(posedge core_clk);
      instr <= a;
      #1;
   endtask : slot

   // clear and or-literal, with an op that does nothing in between
   task automatic test_clr_or();
      csb_pkg::csb_op_t ops [6] = '{csb_pkg::CSB_OP_OR_LIT,
         csb_pkg::CSB_OP_NONE, csb_pkg::CSB_OP_CLR_ACC,
         csb_pkg::CSB_OP_OR_LIT, csb_pkg::CSB_OP_OR_LIT,
         csb_pkg::CSB_OP_CLR_ACC};
      logic [7:0] lit [6] = '{8'h5A, 8'hFF, 8'h00, 8'h00, 8'h81, 8'h00};
      for (int i = 0; i < 6; i++) begin
         slot(mk(ops[i], 7'h00, 1'b0, {3'h0, lit[i]}));
         slot('0);
         if (ops[i] == csb_pkg::CSB_OP_CLR_ACC) begin
            exp_acc = 8'h00;
            exp_zero = 1'b1;
         end else if (ops[i] == csb_pkg::CSB_OP_OR_LIT) begin
            exp_acc = exp_acc | lit[i];
            exp_zero = (exp_acc == 8'h00);
         end
         chk("acc", 13'(exp_acc), 13'(acc_ff));
         chk("zero", 13'(exp_zero), 13'(zero_ff));
      end
      $display("test clr_or done");
   endtask : test_clr_or

   // skips; the slot after each carries or-literal FF as a victim
   task automatic test_skip();
      logic [5:0] inc = 6'b101100;
      logic [5:0] dst = 6'b100011;
      logic [6:0] fa [6] = '{7'h12, 7'h20, 7'h33, 7'h7F, 7'h01, 7'h44};
      logic [7:0] rd [6] = '{8'h05, 8'h01, 8'hFF, 8'h7F, 8'h00, 8'hFE};
      logic [7:0] r;
      logic       sk;
      for (int i = 0; i < 6; i++) begin
         r = inc[i] ? rd[i] + 8'h01 : rd[i] - 8'h01;
         sk = (r == 8'h00);
         @(posedge core_clk);
         instr <= mk(inc[i] ? csb_pkg::CSB_OP_INC_SKIP :
            csb_pkg::CSB_OP_DEC_SKIP, fa[i], dst[i], 11'h000);
         csb_file_model_inst.mem[fa[i]] <= rd[i];
         slot(mk(csb_pkg::CSB_OP_OR_LIT, 7'h00, 1'b0, 11'h0FF));
         if (!dst[i]) exp_acc = r;
         chk("acc", 13'(exp_acc), 13'(acc_ff));
         chk("zero", 13'(exp_zero), 13'(zero_ff));
         chk("wr_en", 13'(dst[i]), 13'(fwr_ff.en));
         if (dst[i]) chk("wr_data", 13'(r), 13'(fwr_ff.data));
         if (dst[i]) chk("wr_addr", 13'(fa[i]), 13'(fwr_ff.addr));
         chk("nop", 13'(sk), 13'(nop_cycle_ff));
         slot('0);
         if (!sk) begin
            exp_acc = 8'hFF;
            exp_zero = 1'b0;
         end
         chk("acc", 13'(exp_acc), 13'(acc_ff));
         chk("nop", 13'h0000, 13'(nop_cycle_ff));
         chk("wr_en", 13'h0000, 13'(fwr_ff.en));
      end
      $display("test skip done");
   endtask : test_skip

   // jumps; a clear in the slot after each must be dropped
   task automatic test_jump();
      logic [10:0] im [4] = '{11'h123, 11'h7FF, 11'h000, 11'h555};
      logic [7:0]  lat [4] = '{8'h18, 8'hE7, 8'h08, 8'h10};
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         instr <= mk(csb_pkg::CSB_OP_JUMP, 7'h00, 1'b0, im[i]);
         page <= lat[i];
         slot(mk(csb_pkg::CSB_OP_CLR_ACC, 7'h00, 1'b0, 11'h000));
         chk("pc", {lat[i][4:3], im[i]}, pc_ff);
         chk("pc_load", 13'h0001, 13'(pc_load_ff));
         chk("nop", 13'h0001, 13'(nop_cycle_ff));
         slot('0);
         chk("pc_load", 13'h0000, 13'(pc_load_ff));
         chk("acc", 13'(exp_acc), 13'(acc_ff));
         chk("zero", 13'(exp_zero), 13'(zero_ff));
      end
      $display("test jump done");
   endtask : test_jump

   // prints counts and verdict, then stops
   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rstn = 1'b0;
      instr = '0;
      page = 8'h00;
      fails = 0;
      compares = 0;
      exp_acc = 8'h00;
      exp_zero = 1'b0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      #1;
      chk("acc", 13'h0000, 13'(acc_ff));
      chk("pc", 13'h0000, pc_ff);
      chk("zero", 13'h0000, 13'(zero_ff));
      chk("nop", 13'h0000, 13'(nop_cycle_ff));
      chk("pc_load", 13'h0000, 13'(pc_load_ff));
      chk("wr_en", 13'h0000, 13'(fwr_ff.en));
      test_clr_or();
      test_skip();
      test_jump();
      finish_test();
   end

   // cuts a hang short
   initial begin
      repeat (3000) @(posedge core_clk);
      fails++;
      finish_test();
   end
endmodule : tb_core_skip_branch_or_ops

`default_nettype wire
